// >>> timer2_capture_reload_uart_ctrl_tb_top.sv
// Self-checking bench: timer modes, serial duplex transfer, register bus.
// Assumes the partner station at 32 cycles per bit (reload 0xFFFF).
`timescale 1ns/100ps
`default_nettype none
module timer2_capture_reload_uart_ctrl_tb_top
    import timer2_uart_pkg::*;
;
    logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, count_pin, trigger_input, timer1_overflow;
    logic double_rate, rx_pin, tx_pin, rx_pin_out, rx_pin_oe, go;
    logic [9:0] awaddr, araddr;
    logic [7:0] rq, send, got;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    int err_total, tests_run, seed;
    timer2_uart timer2_uart_inst (.*);
    timer2_uart_partner timer2_uart_partner_inst (.*);
    initial begin
        aclk = 0;
        forever #50 aclk = ~aclk;
    end
    task results;
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            $display("Error %0t got %h exp %h", $time, g, e);
            err_total++;
        end
    endtask : chk
    // Ready is sampled mid-cycle, so the release lands right after the taking edge
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tr, f;
        f = 0;
        {awaddr, araddr, wdata, wstrb} <= {a, 2'b00, a, 2'b00, 24'h0, d, 4'hF};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        for (int n = 0; n < 50 && !f; n++) begin
            @(negedge aclk);
            {ta, tw, tr} = {awvalid && awready, wvalid && wready, arvalid && arready};
            f = (bvalid && bready) || (rvalid && rready);
            {rq, rr} = {rdata[7:0], w ? bresp : rresp};
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (tr) arvalid <= 0;
            if (f) {bready, rready} <= 2'b00;
        end
        @(posedge aclk);
        if (!f) begin
            err_total++;
            results;
        end
    endtask : bus
    task trig;
        trigger_input <= 0;
        repeat (4) @(posedge aclk);
        trigger_input <= 1;
        @(posedge aclk);
    endtask : trig
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, timer1_overflow, double_rate} = 0;
        {awaddr, araddr, wdata, wstrb, go, send} = 0;
        {aresetn, clk_en, trigger_input, count_pin, seed} = {4'b0111, 32'h3A19};
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        bus(0, SERIAL_CONTROL_OFFS, 8'h00);
        chk(rq, CONTROL_RESET);
        bus(1, RELOAD_LOW_OFFS, 8'h5A);
        bus(0, RELOAD_LOW_OFFS, 8'h00);
        chk(rq, 8'h5A);
        bus(0, 8'h00, 8'h00);
        chk({6'h00, rr}, {6'h00, RESP_SLVERR});
        bus(1, 8'h00, 8'h00);
        chk({6'h00, rr}, {6'h00, RESP_SLVERR});
        bus(1, RELOAD_HIGH_OFFS, 8'h12);
        bus(1, COUNT_HIGH_OFFS, 8'hFF);
        bus(1, COUNT_LOW_OFFS, 8'hF0);
        bus(1, TIMER_CONTROL_OFFS, 8'h04);
        repeat (60) @(posedge aclk);
        bus(0, TIMER_CONTROL_OFFS, 8'h00);
        chk(rq, 8'h84);
        bus(0, COUNT_HIGH_OFFS, 8'h00);
        chk(rq, 8'h12);
        bus(1, COUNT_HIGH_OFFS, 8'h34);
        bus(1, TIMER_CONTROL_OFFS, 8'h0D);
        trig;
        bus(0, RELOAD_HIGH_OFFS, 8'h00);
        chk(rq, 8'h34);
        bus(0, TIMER_CONTROL_OFFS, 8'h00);
        chk(rq, 8'h4D);
        bus(1, TIMER_CONTROL_OFFS, 8'h05);
        trig;
        bus(0, TIMER_CONTROL_OFFS, 8'h00);
        chk(rq, 8'h05);
        bus(1, TIMER_CONTROL_OFFS, 8'h06);
        bus(1, COUNT_LOW_OFFS, 8'h00);
        repeat (6) begin
            count_pin <= ~count_pin;
            repeat (3) @(posedge aclk);
        end
        bus(0, COUNT_LOW_OFFS, 8'h00);
        chk(rq, 8'h03);
        bus(1, TIMER_CONTROL_OFFS, 8'h34);
        bus(1, RELOAD_HIGH_OFFS, 8'hFF);
        bus(1, RELOAD_LOW_OFFS, 8'hFF);
        bus(1, COUNT_HIGH_OFFS, 8'hFF);
        bus(1, COUNT_LOW_OFFS, 8'hFF);
        bus(1, SERIAL_CONTROL_OFFS, 8'h50);
        send = $random(seed);
        go <= 1;
        bus(1, SERIAL_BUFFER_OFFS, 8'hA5);
        repeat (400) @(posedge aclk);
        bus(0, SERIAL_CONTROL_OFFS, 8'h00);
        chk(rq, 8'h57);
        bus(0, SERIAL_BUFFER_OFFS, 8'h00);
        chk(rq, send);
        chk(got, 8'hA5);
        bus(0, TIMER_CONTROL_OFFS, 8'h00);
        chk(rq, 8'h34);
        chk({6'h00, rx_pin_oe, rx_pin_out}, 8'h01);
        results;
    end
endmodule : timer2_capture_reload_uart_ctrl_tb_top
`default_nettype wire

// >>> timer2_uart.sv
// Second timer with capture/reload/baud modes plus the serial port it clocks.
// Registers sit behind an AXI4-Lite slave; pins are synchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module timer2_uart
    import timer2_uart_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [9:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [9:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic count_pin,
    input wire logic trigger_input,
    input wire logic timer1_overflow,
    input wire logic double_rate,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic rx_pin_out,
    output logic rx_pin_oe
);
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_en;
        logic b_pend;
        logic b_err;
        logic r_pend;
        logic [7:0] r_data;
        logic r_err;
        logic [7:0] timer_control;
        logic [7:0] serial_control;
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0] rx_buffer;
        logic count_s1;
        logic count_s2;
        logic count_s3;
        logic trig_s1;
        logic trig_s2;
        logic trig_s3;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic core_div;
        logic [5:0] fix_div;
        tx_state_t tx_state;
        logic [10:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_sub;
        logic tx_line;
        logic tx_clk_line;
        rx_state_t rx_state;
        logic [8:0] rx_shift;
        logic [3:0] rx_bits;
        logic [3:0] rx_sub;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic variable_rate(input logic [7:0] sc);
        return sc[SC_MLO];
    endfunction : variable_rate

    function automatic logic [3:0] frame_len(input logic [7:0] sc);
        return sc[SC_MHI] ? FRAME_BITS_9 : FRAME_BITS_8;
    endfunction : frame_len

    timer_mode_t tmode;
    logic baud_sel;
    logic tick;
    logic overflow;
    logic trig_fall;
    logic ext_event;
    logic aw_go;
    logic ar_go;
    logic rx_last_bit;
    logic buf_write;
    logic tx_tick;
    logic rx_tick;
    logic fixed_tick;
    logic [15:0] count_inc;

    assign awready = !s_reg.aw_held && !s_reg.b_pend;
    assign wready = !s_reg.w_held && !s_reg.b_pend;
    assign bvalid = s_reg.b_pend;
    assign bresp = s_reg.b_err ? RESP_SLVERR : RESP_OKAY;
    assign arready = !s_reg.r_pend;
    assign rvalid = s_reg.r_pend;
    assign rdata = {24'h000000, s_reg.r_data};
    assign rresp = s_reg.r_err ? RESP_SLVERR : RESP_OKAY;
    assign tx_pin = s_reg.tx_clk_line;
    assign rx_pin_out = s_reg.tx_line;
    // Mode 0 drives data on the receive pin only while transmitting; other modes only listen there
    assign rx_pin_oe = (s_reg.serial_control[SC_MHI:SC_MLO] == 2'b00) &&
        (s_reg.tx_state == TX_SHIFT);

    always_comb begin
        s_next = s_reg;
        // R9 mode table, run bit wins
        baud_sel = s_reg.timer_control[TC_RCLK] | s_reg.timer_control[TC_TX_CLOCK_SELECT];
        // R6 off whatever else is set
        if (!s_reg.timer_control[TC_RUN]) begin
            tmode = TM_OFF;
        end else if (baud_sel) begin
            tmode = TM_BAUD;
        end else if (s_reg.timer_control[TC_CAP]) begin
            tmode = TM_CAPTURE;
        end else begin
            tmode = TM_RELOAD;
        end
        s_next.count_s1 = count_pin;
        s_next.count_s2 = s_reg.count_s1;
        s_next.count_s3 = s_reg.count_s2;
        s_next.trig_s1 = trigger_input;
        s_next.trig_s2 = s_reg.trig_s1;
        s_next.trig_s3 = s_reg.trig_s2;
        s_next.rx_s1 = rx_pin;
        s_next.rx_s2 = s_reg.rx_s1;
        s_next.rx_s3 = s_reg.rx_s2;
        // Core-clock timer ticks every two clocks, matching baud-mode increment
        s_next.core_div = !s_reg.core_div;
        // R7 count source; R25 synchronised falling edges
        if (s_reg.timer_control[TC_CNT]) begin
            tick = s_reg.count_s3 && !s_reg.count_s2;
        end else begin
            tick = s_reg.core_div;
        end
        tick = tick && (tmode != TM_OFF);
        count_inc = s_reg.count + 16'h0001;
        overflow = tick && (s_reg.count == 16'hFFFF);
        // R5 trigger ignored unless enabled and not clocking serial port
        trig_fall = s_reg.trig_s3 && !s_reg.trig_s2;
        ext_event = trig_fall && s_reg.timer_control[TC_EXEN] &&
            (tmode == TM_RELOAD || tmode == TM_CAPTURE);
        if (tick) begin
            s_next.count = count_inc;
        end
        // R10 R8 R12 reload on overflow unless capturing
        if (overflow && tmode != TM_CAPTURE) begin
            s_next.count = s_reg.reload;
        end
        // R11 trigger-driven reload
        if (ext_event && tmode == TM_RELOAD) begin
            s_next.count = s_reg.reload;
        end
        // R13 capture count into reload pair
        if (ext_event && tmode == TM_CAPTURE) begin
            s_next.reload = s_reg.count;
        end

        // R23 R3 R4 bit clocks from chosen overflow source
        tx_tick = s_reg.timer_control[TC_TX_CLOCK_SELECT] ? overflow : timer1_overflow;
        rx_tick = s_reg.timer_control[TC_RCLK] ? overflow : timer1_overflow;
        rx_last_bit = s_reg.serial_control[SC_MHI] ? s_reg.rx_shift[8] : s_reg.rx_s2;
        s_next.fix_div = s_reg.fix_div + 6'h01;
        // R17 fixed rates for modes 0 and 2
        if (!s_reg.serial_control[SC_MHI]) begin
            fixed_tick = s_reg.fix_div[0] == MODE0_DIV[0];
            if (fixed_tick) begin
                s_next.fix_div = 6'h00;
            end
        end else if (double_rate) begin
            fixed_tick = s_reg.fix_div == MODE2_DIV_FAST;
            if (fixed_tick) begin
                s_next.fix_div = 6'h00;
            end
        end else begin
            fixed_tick = s_reg.fix_div == MODE2_DIV_SLOW;
        end
        if (!variable_rate(s_reg.serial_control)) begin
            tx_tick = fixed_tick;
            rx_tick = fixed_tick;
        end

        aw_go = awvalid && awready;
        ar_go = arvalid && arready;
        if (aw_go) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = awaddr[9:2];
        end
        if (wvalid && wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = wdata[7:0];
            s_next.w_en = wstrb[0];
        end
        buf_write = 1'b0;
        if (s_reg.aw_held && s_reg.w_held) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.b_pend = 1'b1;
            s_next.b_err = 1'b0;
            case (s_reg.aw_addr)
                TIMER_CONTROL_OFFS: begin
                    if (s_reg.w_en) begin
                        s_next.timer_control = s_reg.w_data;
                    end
                end
                SERIAL_CONTROL_OFFS: begin
                    if (s_reg.w_en) begin
                        s_next.serial_control = s_reg.w_data;
                    end
                end
                // R16 write side is the transmit register
                SERIAL_BUFFER_OFFS: begin
                    buf_write = s_reg.w_en;
                end
                RELOAD_LOW_OFFS: begin
                    if (s_reg.w_en) begin
                        s_next.reload[7:0] = s_reg.w_data;
                    end
                end
                RELOAD_HIGH_OFFS: begin
                    if (s_reg.w_en) begin
                        s_next.reload[15:8] = s_reg.w_data;
                    end
                end
                COUNT_LOW_OFFS: begin
                    if (s_reg.w_en) begin
                        s_next.count[7:0] = s_reg.w_data;
                    end
                end
                COUNT_HIGH_OFFS: begin
                    if (s_reg.w_en) begin
                        s_next.count[15:8] = s_reg.w_data;
                    end
                end
                default: begin
                    s_next.b_err = 1'b1;
                end
            endcase
        end
        if (s_reg.b_pend && bready) begin
            s_next.b_pend = 1'b0;
        end
        if (ar_go) begin
            s_next.r_pend = 1'b1;
            s_next.r_err = 1'b0;
            case (araddr[9:2])
                TIMER_CONTROL_OFFS: s_next.r_data = s_reg.timer_control;
                SERIAL_CONTROL_OFFS: s_next.r_data = s_reg.serial_control;
                // R16 read side is the separate receive register
                SERIAL_BUFFER_OFFS: s_next.r_data = s_reg.rx_buffer;
                RELOAD_LOW_OFFS: s_next.r_data = s_reg.reload[7:0];
                RELOAD_HIGH_OFFS: s_next.r_data = s_reg.reload[15:8];
                COUNT_LOW_OFFS: s_next.r_data = s_reg.count[7:0];
                COUNT_HIGH_OFFS: s_next.r_data = s_reg.count[15:8];
                default: begin
                    s_next.r_data = 8'h00;
                    s_next.r_err = 1'b1;
                end
            endcase
        end else if (s_reg.r_pend && rready) begin
            s_next.r_pend = 1'b0;
        end
        // R1 R14 overflow flag, blocked in baud mode; set beats clear
        if (overflow && !baud_sel) begin
            s_next.timer_control[TC_OVF] = 1'b1;
        end
        // R2 external flag, also in baud mode via capture-free path
        if (trig_fall && s_reg.timer_control[TC_EXEN] && tmode != TM_OFF) begin
            s_next.timer_control[TC_EXT] = s_next.timer_control[TC_EXT] | ext_event |
                (tmode == TM_BAUD);
        end

        // R15 transmitter runs independently of receiver
        case (s_reg.tx_state)
            TX_IDLE: begin
                s_next.tx_line = 1'b1;
                s_next.tx_clk_line = !variable_rate(s_reg.serial_control) &&
                    !s_reg.serial_control[SC_MHI] ? 1'b1 : s_reg.tx_line;
                if (buf_write) begin
                    s_next.tx_state = TX_SHIFT;
                    s_next.tx_bits = 4'h0;
                    s_next.tx_sub = 4'h0;
                    // R24 R20 start bit, data LSB first, ninth bit, stop
                    if (s_reg.serial_control[SC_MHI:SC_MLO] == 2'b00) begin
                        s_next.tx_shift = {3'b111, s_reg.w_data};
                    end else if (s_reg.serial_control[SC_MHI]) begin
                        s_next.tx_shift = {1'b1, s_reg.serial_control[SC_TB8],
                            s_reg.w_data, 1'b0};
                    end else begin
                        s_next.tx_shift = {2'b11, s_reg.w_data, 1'b0};
                    end
                end
            end
            TX_SHIFT: begin
                if (s_reg.serial_control[SC_MHI:SC_MLO] == 2'b00) begin
                    s_next.tx_line = s_reg.tx_shift[0];
                    if (fixed_tick) begin
                        s_next.tx_clk_line = !s_reg.tx_clk_line;
                        if (s_reg.tx_clk_line) begin
                            s_next.tx_bits = s_reg.tx_bits + 4'h1;
                        end else if (s_reg.tx_bits != 4'h0) begin
                            s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                        end
                    end
                    // R21 flag at end of eighth bit in shift mode
                    if (s_reg.tx_bits == SHIFT_BITS) begin
                        s_next.serial_control[SC_TI] = 1'b1;
                        s_next.tx_state = TX_IDLE;
                    end
                end else begin
                    s_next.tx_line = s_reg.tx_shift[0];
                    s_next.tx_clk_line = s_reg.tx_shift[0];
                    if (tx_tick) begin
                        s_next.tx_sub = s_reg.tx_sub + 4'h1;
                        if (s_reg.tx_sub == OVF_PER_BIT ||
                            !variable_rate(s_reg.serial_control)) begin
                            s_next.tx_sub = 4'h0;
                            s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                            s_next.tx_bits = s_reg.tx_bits + 4'h1;
                            // R21 flag as the stop bit starts
                            if (s_reg.tx_bits + 4'h1 == frame_len(s_reg.serial_control)) begin
                                s_next.serial_control[SC_TI] = 1'b1;
                            end
                            if (s_reg.tx_bits == frame_len(s_reg.serial_control)) begin
                                s_next.tx_state = TX_IDLE;
                            end
                        end
                    end
                end
            end
            default: s_next.tx_state = TX_IDLE;
        endcase

        // R19 reception only with receive enable
        case (s_reg.rx_state)
            RX_IDLE: begin
                s_next.rx_sub = 4'h0;
                s_next.rx_bits = 4'h0;
                if (s_reg.serial_control[SC_REN]) begin
                    if (s_reg.serial_control[SC_MHI:SC_MLO] == 2'b00) begin
                        if (!s_reg.serial_control[SC_RI]) begin
                            s_next.rx_state = RX_SHIFT0;
                        end
                    end else if (s_reg.rx_s3 && !s_reg.rx_s2) begin
                        s_next.rx_state = RX_START;
                    end
                end
            end
            RX_START: begin
                if (rx_tick) begin
                    s_next.rx_sub = s_reg.rx_sub + 4'h1;
                    if (s_reg.rx_sub == SAMPLE_MID ||
                        !variable_rate(s_reg.serial_control)) begin
                        s_next.rx_sub = 4'h0;
                        // False start: line back high at mid-bit
                        s_next.rx_state = s_reg.rx_s2 ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    s_next.rx_sub = s_reg.rx_sub + 4'h1;
                    if (s_reg.rx_sub == OVF_PER_BIT ||
                        !variable_rate(s_reg.serial_control)) begin
                        s_next.rx_sub = 4'h0;
                        s_next.rx_shift = {s_reg.rx_s2, s_reg.rx_shift[8:1]};
                        s_next.rx_bits = s_reg.rx_bits + 4'h1;
                        // R22 mid stop bit: last sample ends the frame
                        if (s_reg.rx_bits + 4'h1 == frame_len(s_reg.serial_control)) begin
                            s_next.rx_state = RX_IDLE;
                            // R18 multiprocessor filter on ninth or stop bit
                            if (!s_reg.serial_control[SC_RI] &&
                                (!s_reg.serial_control[SC_MP] || rx_last_bit)) begin
                                // R15 unread byte is kept: a frame ending while the receive flag is set is dropped
                                s_next.rx_buffer = s_reg.serial_control[SC_MHI] ?
                                    s_reg.rx_shift[7:0] : s_reg.rx_shift[8:1];
                                // R20 ninth bit or stop bit
                                s_next.serial_control[SC_RB8] = rx_last_bit;
                                s_next.serial_control[SC_RI] = 1'b1;
                            end
                        end
                    end
                end
            end
            RX_SHIFT0: begin
                if (fixed_tick && s_reg.tx_clk_line) begin
                    s_next.rx_shift = {s_reg.rx_s2, s_reg.rx_shift[8:1]};
                    s_next.rx_bits = s_reg.rx_bits + 4'h1;
                    if (s_reg.rx_bits == SHIFT_BITS - 4'h1) begin
                        s_next.rx_buffer = {s_reg.rx_s2, s_reg.rx_shift[8:2]};
                        // R22 flag at end of eighth bit
                        s_next.serial_control[SC_RI] = 1'b1;
                        s_next.rx_state = RX_IDLE;
                    end
                end
            end
            default: s_next.rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.timer_control <= CONTROL_RESET;
            s_reg.serial_control <= CONTROL_RESET;
            s_reg.tx_line <= 1'b1;
            s_reg.tx_clk_line <= 1'b1;
            s_reg.count_s1 <= 1'b1;
            s_reg.count_s2 <= 1'b1;
            s_reg.count_s3 <= 1'b1;
            s_reg.trig_s1 <= 1'b1;
            s_reg.trig_s2 <= 1'b1;
            s_reg.trig_s3 <= 1'b1;
            s_reg.rx_s1 <= 1'b1;
            s_reg.rx_s2 <= 1'b1;
            s_reg.rx_s3 <= 1'b1;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end
endmodule : timer2_uart
`default_nettype wire

// >>> timer2_uart_partner.sv
// Remote mode 1 serial station: sends one byte on go, captures what arrives.
// Assumes a fixed bit time in aclk cycles.
`timescale 1ns/100ps
`default_nettype none
module timer2_uart_partner #(parameter int BIT = 32) (
    input wire logic aclk,
    input wire logic tx_pin,
    input wire logic go,
    input wire logic [7:0] send,
    output logic rx_pin,
    output logic [7:0] got
);
    initial rx_pin = 1;
    always @(posedge go) begin
        rx_pin <= 0;
        repeat (BIT) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            rx_pin <= send[i];
            repeat (BIT) @(posedge aclk);
        end
        rx_pin <= 1;
    end
    always @(negedge tx_pin) begin
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge aclk);
            got[i] = tx_pin;
        end
        repeat (BIT) @(posedge aclk);
    end
endmodule : timer2_uart_partner
`default_nettype wire

// >>> timer2_uart_pkg.sv
// Constants, register map and types for the second timer and serial port.
// Assumes a single 10 MHz core clock and an AXI4-Lite register master.
// Notes on behaviour
// R1: Overflow flag sets on timer overflow, never while a serial clock select is on.
// R2: External flag sets when an enabled trigger falling edge causes capture or reload.
// R3: Receive clock select picks timer overflow, else first-timer overflow, modes 1 and 3.
// R4: Transmit clock select picks timer overflow, else first-timer overflow, modes 1 and 3.
// R5: External enable allows trigger edges unless the timer clocks the serial port.
// R6: Run bit starts and stops the timer; cleared means off.
// R7: Function select counts count-pin edges, else core clock ticks.
// R8: Capture select picks capture, else reload; forced reload in baud mode.
// R9: Mode table: autoreload, capture, baud generation, off.
// R10: Autoreload rollover sets overflow flag and loads the reload pair.
// R11: Autoreload with external enable: trigger fall reloads and sets external flag.
// R12: Capture mode runs free and sets overflow flag on overflow.
// R13: Capture mode trigger fall copies count into reload pair, sets external flag.
// R14: Baud mode never raises overflow flag; external flag still settable.
// R15: Full duplex; second reception may overwrite an unread first byte. Here it is dropped while the receive flag is set.
// R16: Buffer write loads transmit register; read returns separate receive register.
// R17: Serial modes: 00 shift, 01 8-bit variable, 10 9-bit fixed, 11 9-bit variable.
// R18: Multiprocessor bit suppresses receive flag on ninth bit 0 or bad stop.
// R19: Receive enable permits reception.
// R20: Ninth transmit bit sent in modes 2, 3; ninth receive bit latched, stop in mode 1.
// R21: Transmit flag set after eighth bit mode 0, at stop start otherwise.
// R22: Receive flag set after eighth bit mode 0, mid stop otherwise.
// R23: Timer-clocked serial port needs 16 overflows per bit.
// R24: Mode 1 frame: 0 start, 8 data LSB first, 1 stop, 10 bits.
// R25: Counter function syncs count pin and counts falling edges while running.
package timer2_uart_pkg;
    // Register indices: byte address is four times the index
    localparam logic [7:0] SERIAL_CONTROL_OFFS = 8'h98;
    localparam logic [7:0] SERIAL_BUFFER_OFFS = 8'h99;
    localparam logic [7:0] RELOAD_LOW_OFFS = 8'hCA;
    localparam logic [7:0] RELOAD_HIGH_OFFS = 8'hCB;
    localparam logic [7:0] COUNT_LOW_OFFS = 8'hCC;
    localparam logic [7:0] COUNT_HIGH_OFFS = 8'hCD;
    localparam logic [7:0] TIMER_CONTROL_OFFS = 8'hC8;
    localparam int TC_OVF = 7;
    localparam int TC_EXT = 6;
    localparam int TC_RCLK = 5;
    localparam int TC_TX_CLOCK_SELECT = 4;
    localparam int TC_EXEN = 3;
    localparam int TC_RUN = 2;
    localparam int TC_CNT = 1;
    localparam int TC_CAP = 0;
    localparam int SC_MHI = 7;
    localparam int SC_MLO = 6;
    localparam int SC_MP = 5;
    localparam int SC_REN = 4;
    localparam int SC_TB8 = 3;
    localparam int SC_RB8 = 2;
    localparam int SC_TI = 1;
    localparam int SC_RI = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [3:0] OVF_PER_BIT = 4'hF;
    localparam logic [3:0] SAMPLE_MID = 4'h7;
    localparam logic [5:0] MODE2_DIV_SLOW = 6'h3F;
    localparam logic [5:0] MODE2_DIV_FAST = 6'h1F;
    localparam logic [5:0] MODE0_DIV = 6'h01;
    localparam logic [3:0] FRAME_BITS_8 = 4'h9;
    localparam logic [3:0] FRAME_BITS_9 = 4'hA;
    localparam logic [3:0] SHIFT_BITS = 4'h8;
    typedef enum logic [1:0] {TM_OFF, TM_RELOAD, TM_CAPTURE, TM_BAUD} timer_mode_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT0} rx_state_t;
endpackage : timer2_uart_pkg

// >>> timer2_uart_sva.sv
// Register bus and line checks on the ports of timer2_uart.
// Assumes binding to the top module.
`timescale 1ns/100ps
`default_nettype none
module timer2_uart_sva
    import timer2_uart_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic tx_pin
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken_s; awvalid && awready && wvalid && wready; endsequence
    sequence rd_taken_s; arvalid && arready; endsequence
    rd_answer_a: assert property (rd_taken_s |=> rvalid)
        else $error("read answer not one cycle after address");
    wr_answer_a: assert property (wr_taken_s |-> ##2 bvalid)
        else $error("write answer not two cycles after taking");
    rd_once_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    wr_once_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer repeated");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("read address taken while answer pending");
    aw_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    rd_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    err_zero_a: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
        else $error("refused read carries data");
    tx_idle_a: assert property ($rose(aresetn) |-> tx_pin)
        else $error("transmit line not idle high after reset");
endmodule : timer2_uart_sva
bind timer2_uart timer2_uart_sva timer2_uart_sva_inst (.*);
`default_nettype wire
